// *** design/ssd_monitor_top.sv ***
// Bank of safety status diagnostics monitors with APB registers
// What this block does
// - Each monitor works only while its activation coil is driven.
// - Status output mirrors the monitored block's hex status code, cut to its low byte in byte marker width.
// - Contact vector: byte 0 holds contacts 1 to 8, upper bytes zero.
// - Each contact closes while its selected status is present.
// - Group contact is the OR of the eight state contacts.
// - Each monitor holds exactly eight configurable status selections.
// - Two monitors may watch the same safety block for extra states.
// - Per-monitor parameter visibility setting, default shown.
// - Outputs fit double word, word or byte marker storage only.
// - Sixteen independent monitor instances.
module ssd_monitor_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ssd_pkg::AW-1:0] paddr,
	input wire logic [ssd_pkg::DW-1:0] pwdata,
	output logic [ssd_pkg::DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Monitored safety blocks
	input wire logic [ssd_pkg::NUM_MON-1:0] monitor_activate_coil,
	input wire logic [ssd_pkg::NUM_MON-1:0][ssd_pkg::CODE_W-1:0] safety_code,
	// Marker outputs
	output logic [ssd_pkg::NUM_MON-1:0][ssd_pkg::DW-1:0] status_code_out,
	output logic [ssd_pkg::NUM_MON-1:0][ssd_pkg::DW-1:0] contact_vector_out,
	output logic [ssd_pkg::NUM_MON-1:0][ssd_pkg::NUM_CT-1:0] state_contacts,
	output logic [ssd_pkg::NUM_MON-1:0] state_group_contact,
	output logic [ssd_pkg::NUM_MON-1:0] param_visible,
	// Interrupt
	output logic irq
);
	import ssd_pkg::*;

	// ********************************************************
	// Configuration storage
	// ********************************************************
	logic [NUM_MON-1:0][CTRL_W-1:0] ctrl_q;
	logic [NUM_MON-1:0][CTRL_W-1:0] ctrl_d;
	logic [NUM_MON-1:0][NUM_CT-1:0][CODE_W-1:0] sel_q;
	logic [NUM_MON-1:0][NUM_CT-1:0][CODE_W-1:0] sel_d;

	// ********************************************************
	// Output state
	// ********************************************************
	logic [NUM_MON-1:0][DW-1:0] status_q;
	logic [NUM_MON-1:0][DW-1:0] status_d;
	logic [NUM_MON-1:0][DW-1:0] vector_q;
	logic [NUM_MON-1:0][DW-1:0] vector_d;
	logic [NUM_MON-1:0][NUM_CT-1:0] contact_q;
	logic [NUM_MON-1:0][NUM_CT-1:0] contact_d;
	logic [NUM_MON-1:0] group_q;
	logic [NUM_MON-1:0] group_d;
	logic [NUM_MON-1:0] vis_q;
	logic [NUM_MON-1:0] vis_d;

	// ********************************************************
	// Bus state
	// ********************************************************
	logic [DW-1:0] prdata_q;
	logic [DW-1:0] prdata_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;

	// ********************************************************
	// Internal nets
	// ********************************************************
	logic [NUM_MON-1:0][CODE_W-1:0] src_code;
	logic [NUM_MON-1:0][NUM_CT-1:0] hit;
	logic [NUM_MON-1:0] grp_rise;
	logic [NUM_MON-1:0] irq_status;
	logic [NUM_MON-1:0] irq_enable;
	logic irq_q;
	logic acc;
	logic wr_done;
	logic in_bank;
	logic [SRC_W-1:0] inst;
	logic [5:0] off;
	logic irq_clr_we;
	logic irq_en_we;

	// ********************************************************
	// Address decode
	// ********************************************************
	always_comb begin
		acc = psel && penable;
		wr_done = acc && pready_q && pwrite;
		in_bank = (paddr[11:10] == 2'h0);
		inst = paddr[9:6];
		off = paddr[5:0];
		irq_clr_we = wr_done && (paddr == OFF_IRQ_CLEAR);
		irq_en_we = wr_done && (paddr == OFF_IRQ_ENABLE);
	end

	// ********************************************************
	// Source select and status matching
	// ********************************************************
	always_comb begin
		for (int m = 0; m < NUM_MON; m++) begin
			// Any monitor may point at any block, so two can share one
			src_code[m] = safety_code[ctrl_q[m][CTRL_SRC_LSB +: SRC_W]];
		end
	end

	// One matcher with eight selections per monitor
	for (genvar g = 0; g < NUM_MON; g++) begin : g_mon
		ssd_match u_match (
			.active(monitor_activate_coil[g]),
			.code(src_code[g]),
			.sel(sel_q[g]),
			.hit(hit[g])
		);
	end

	// ********************************************************
	// Monitor outputs
	// ********************************************************
	always_comb begin
		for (int m = 0; m < NUM_MON; m++) begin
			if (monitor_activate_coil[m]) begin
				status_d[m] = ssd_fit({16'h0000, src_code[m]},
					ctrl_q[m][CTRL_WID_LSB +: 2]);
				contact_d[m] = hit[m];
			end else begin
				status_d[m] = '0;
				contact_d[m] = '0;
			end
			group_d[m] = |contact_d[m];
			vector_d[m] = ssd_fit({24'h000000, contact_d[m]},
				ctrl_q[m][CTRL_WID_LSB +: 2]);
			vis_d[m] = ctrl_q[m][CTRL_VIS_BIT];
			grp_rise[m] = group_d[m] && !group_q[m];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_q <= '0;
			vector_q <= '0;
			contact_q <= '0;
			group_q <= '0;
			vis_q <= '1;
		end else begin
			status_q <= status_d;
			vector_q <= vector_d;
			contact_q <= contact_d;
			group_q <= group_d;
			vis_q <= vis_d;
		end
	end

	// ********************************************************
	// Configuration writes
	// ********************************************************
	always_comb begin
		ctrl_d = ctrl_q;
		sel_d = sel_q;
		if (wr_done && in_bank) begin
			unique case (off)
				OFF_CTRL: begin
					ctrl_d[inst] = pwdata[CTRL_W-1:0];
				end
				OFF_SEL01, OFF_SEL23, OFF_SEL45, OFF_SEL67: begin
					sel_d[inst][{off[4:2] - 3'h1, 1'b0}] = pwdata[15:0];
					sel_d[inst][{off[4:2] - 3'h1, 1'b1}] = pwdata[31:16];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int m = 0; m < NUM_MON; m++) begin
				// Each monitor starts on the block of its own number
				ctrl_q[m] <= CTRL_RST | CTRL_W'(m << CTRL_SRC_LSB);
			end
			sel_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			sel_q <= sel_d;
		end
	end

	// ********************************************************
	// APB read and answer
	// ********************************************************
	always_comb begin
		prdata_d = '0;
		pslverr_d = 1'b0;
		pready_d = acc && !pready_q;
		if (acc && !pready_q) begin
			if (in_bank) begin
				unique case (off)
					OFF_CTRL: begin
						prdata_d = {24'h000000, ctrl_q[inst]};
					end
					OFF_SEL01, OFF_SEL23, OFF_SEL45, OFF_SEL67: begin
						prdata_d = {sel_q[inst][{off[4:2] - 3'h1, 1'b1}],
							sel_q[inst][{off[4:2] - 3'h1, 1'b0}]};
					end
					OFF_STATUS: begin
						prdata_d = status_q[inst];
					end
					OFF_VECTOR: begin
						prdata_d = vector_q[inst];
					end
					default: begin
						pslverr_d = 1'b1;
					end
				endcase
			end else if (paddr == OFF_IRQ_STATUS) begin
				prdata_d = {16'h0000, irq_status};
			end else if (paddr == OFF_IRQ_ENABLE) begin
				prdata_d = {16'h0000, irq_enable};
			end else if (paddr != OFF_IRQ_CLEAR) begin
				pslverr_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// ********************************************************
	// Interrupt on group contact closing
	// ********************************************************
	ssd_irq u_irq (
		.clk(clk),
		.rst(rst),
		.ev(grp_rise),
		.clr_we(irq_clr_we),
		.en_we(irq_en_we),
		.wdata(pwdata[NUM_MON-1:0]),
		.status_q(irq_status),
		.enable_q(irq_enable),
		.irq_q(irq_q)
	);

	// ********************************************************
	// Port drive
	// ********************************************************
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign status_code_out = status_q;
	assign contact_vector_out = vector_q;
	assign state_contacts = contact_q;
	assign state_group_contact = group_q;
	assign param_visible = vis_q;
	assign irq = irq_q;

	// ********************************************************
	// Assertions
	// ********************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// ********************************************************
	// Bus answer timing
	// ********************************************************
	sequence apb_wait_s;
		psel && penable && !pready;
	endsequence
	sequence apb_answer_s;
		##1 pready ##1 !pready;
	endsequence

	apb_answer_a: assert property (
		apb_wait_s |-> apb_answer_s)
		else $error("Bus answer not after one wait state");

	for (genvar g = 0; g < NUM_MON; g++) begin : g_chk
		sequence ctrl_write_s;
			wr_done && in_bank && inst == SRC_W'(g) && off == OFF_CTRL;
		endsequence
		sequence vis_follow_s;
			##2 param_visible[g] == $past(pwdata[CTRL_VIS_BIT], 2);
		endsequence

		monitor_idle_a: assert property (
			!monitor_activate_coil[g] |=>
			status_code_out[g] == '0 && !state_group_contact[g])
			else $error("Idle monitor drives outputs");
		code_mirror_a: assert property (
			monitor_activate_coil[g] |=> status_code_out[g] ==
			ssd_fit({16'h0000, $past(src_code[g])},
			$past(ctrl_q[g][CTRL_WID_LSB +: 2])))
			else $error("Status code not mirrored");
		vector_pack_a: assert property (
			contact_vector_out[g] == {24'h000000, state_contacts[g]})
			else $error("Contact vector misplaced");
		contact_hit_a: assert property (
			monitor_activate_coil[g] && sel_q[g][0] != SEL_NONE &&
			sel_q[g][0] == src_code[g] |=> state_contacts[g][0])
			else $error("Selected status did not close contact");
		group_or_a: assert property (
			state_group_contact[g] == |state_contacts[g])
			else $error("Group contact is not the OR");
		param_vis_a: assert property (
			ctrl_write_s |-> vis_follow_s)
			else $error("Visibility setting not applied");
		marker_byte_a: assert property (
			ctrl_q[g][CTRL_WID_LSB +: 2] == SSD_MK_BYTE |=>
			status_code_out[g][31:8] == '0)
			else $error("Byte marker width exceeded");
		contact_off_a: assert property (
			!monitor_activate_coil[g] |=>
			state_contacts[g] == '0 && contact_vector_out[g] == '0)
			else $error("Contacts closed without coil");
		contact_open_a: assert property (
			monitor_activate_coil[g] && sel_q[g][0] != src_code[g] |=>
			!state_contacts[g][0])
			else $error("Contact closed without its status");
		contact_eight_a: assert property (
			monitor_activate_coil[g] && sel_q[g][7] != SEL_NONE &&
			sel_q[g][7] == src_code[g] |=> contact_vector_out[g][7])
			else $error("Last contact not in vector bit seven");
		marker_word_a: assert property (
			ctrl_q[g][CTRL_WID_LSB +: 2] == SSD_MK_WORD |=>
			status_code_out[g][31:16] == '0)
			else $error("Word marker width exceeded");
		irq_set_a: assert property (
			$rose(state_group_contact[g]) |-> irq_status[g])
			else $error("Group closing did not set status");
	end

endmodule

// *** design/ssd_pkg.sv ***
// Shared constants, types and helpers of the safety status diagnostics block
package ssd_pkg;

	// ********************************************************
	// Sizes
	// ********************************************************
	localparam int NUM_MON = 16;
	localparam int NUM_CT = 8;
	localparam int CODE_W = 16;
	localparam int DW = 32;
	localparam int CTRL_W = 8;
	localparam int SRC_W = 4;
	localparam int AW = 12;

	// ********************************************************
	// Register offsets
	// ********************************************************
	localparam logic [5:0] OFF_CTRL = 6'h00;
	localparam logic [5:0] OFF_SEL01 = 6'h04;
	localparam logic [5:0] OFF_SEL23 = 6'h08;
	localparam logic [5:0] OFF_SEL45 = 6'h0C;
	localparam logic [5:0] OFF_SEL67 = 6'h10;
	localparam logic [5:0] OFF_STATUS = 6'h14;
	localparam logic [5:0] OFF_VECTOR = 6'h18;
	localparam logic [AW-1:0] OFF_IRQ_STATUS = 12'h400;
	localparam logic [AW-1:0] OFF_IRQ_CLEAR = 12'h404;
	localparam logic [AW-1:0] OFF_IRQ_ENABLE = 12'h408;

	// ********************************************************
	// Control field layout and reset values
	// ********************************************************
	localparam int CTRL_VIS_BIT = 0;
	localparam int CTRL_WID_LSB = 1;
	localparam int CTRL_SRC_LSB = 4;
	localparam logic [CTRL_W-1:0] CTRL_RST = 8'h01;
	localparam logic [CODE_W-1:0] SEL_RST = 16'h0000;
	localparam logic [CODE_W-1:0] SEL_NONE = 16'h0000;
	localparam logic [NUM_MON-1:0] IRQ_EN_RST = 16'h0000;

	// ********************************************************
	// Marker width
	// ********************************************************
	typedef enum logic [1:0] {
		SSD_MK_DWORD = 2'h0,
		SSD_MK_WORD = 2'h1,
		SSD_MK_BYTE = 2'h2
	} ssd_mwid_t;

	function automatic logic [DW-1:0] ssd_fit(input logic [DW-1:0] v,
		input logic [1:0] w);
		logic [DW-1:0] r;
		r = v;
		if (w == SSD_MK_WORD) begin
			r = {16'h0000, v[15:0]};
		end else if (w == SSD_MK_BYTE) begin
			r = {24'h000000, v[7:0]};
		end
		return r;
	endfunction

endpackage

// *** design/ssd_match.sv ***
// Compares one status code against eight status selections
module ssd_match (
	// Monitored code
	input wire logic active,
	input wire logic [ssd_pkg::CODE_W-1:0] code,
	// Selections
	input wire logic [ssd_pkg::NUM_CT-1:0][ssd_pkg::CODE_W-1:0] sel,
	// Matches
	output logic [ssd_pkg::NUM_CT-1:0] hit
);
	import ssd_pkg::*;

	always_comb begin
		for (int i = 0; i < NUM_CT; i++) begin
			hit[i] = active && (sel[i] != SEL_NONE) && (sel[i] == code);
		end
	end

endmodule

// *** design/ssd_irq.sv ***
// Sticky event status, enable and clear with one level interrupt
module ssd_irq (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Events
	input wire logic [ssd_pkg::NUM_MON-1:0] ev,
	// Software access
	input wire logic clr_we,
	input wire logic en_we,
	input wire logic [ssd_pkg::NUM_MON-1:0] wdata,
	// State
	output logic [ssd_pkg::NUM_MON-1:0] status_q,
	output logic [ssd_pkg::NUM_MON-1:0] enable_q,
	output logic irq_q
);
	import ssd_pkg::*;

	logic [NUM_MON-1:0] status_d;
	logic [NUM_MON-1:0] enable_d;
	logic irq_d;

	always_comb begin
		status_d = status_q;
		if (clr_we) begin
			status_d = status_q & ~wdata;
		end
		status_d = status_d | ev;
		enable_d = en_we ? wdata : enable_q;
		irq_d = |(status_d & enable_d);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_q <= '0;
			enable_q <= IRQ_EN_RST;
			irq_q <= 1'b0;
		end else begin
			status_q <= status_d;
			enable_q <= enable_d;
			irq_q <= irq_d;
		end
	end

endmodule

// *** verification/ssd_safety_model.sv ***
// Model of the monitored safety blocks and their diagnostics registers
module ssd_safety_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Code update from the bench
	input wire logic set_en,
	input wire logic [3:0] set_idx,
	input wire logic [15:0] set_val,
	// Diagnostics registers
	output logic [ssd_pkg::NUM_MON-1:0][ssd_pkg::CODE_W-1:0] safety_code
);
	timeunit 1ns;
	timeprecision 1ns;
	import ssd_pkg::*;

	// ********************************************************
	// Hex status code of each block
	// ********************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			safety_code <= '0;
		end else if (set_en) begin
			safety_code[set_idx] <= set_val;
		end
	end
endmodule

// *** verification/test_safety_status_diagnostics.sv ***
// Self-checking bench of the status monitor bank
module test_safety_status_diagnostics;
	timeunit 1ns;
	timeprecision 1ns;
	import ssd_pkg::*;

	logic clk, rst, psel, penable, pwrite, pready, pslverr, irq;
	logic [AW-1:0] paddr;
	logic [DW-1:0] pwdata, prdata, r;
	logic e, set_en;
	logic [3:0] set_idx;
	logic [15:0] set_val, coil, vis, grp;
	logic [NUM_MON-1:0][CODE_W-1:0] code;
	logic [NUM_MON-1:0][DW-1:0] st_out, vec_out;
	logic [NUM_MON-1:0][NUM_CT-1:0] ct;
	int n_fail, checks_done, cyc, i;

	ssd_safety_model model (.clk(clk), .rst(rst), .set_en(set_en),
		.set_idx(set_idx), .set_val(set_val), .safety_code(code));

	ssd_monitor_top dut (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .monitor_activate_coil(coil),
		.safety_code(code), .status_code_out(st_out),
		.contact_vector_out(vec_out), .state_contacts(ct),
		.state_group_contact(grp), .param_visible(vis), .irq(irq));

	// ********************************************************
	// Clock, timeout and report
	// ********************************************************
	always #50 clk = ~clk;

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_of_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		checks_done++;
		if (got !== ex) begin
			$display("ERROR %s expected %h seen %h", nm, ex, got);
			n_fail++;
		end
	endtask

	// ********************************************************
	// Access tasks
	// ********************************************************
	task automatic apb(input logic w, input logic [AW-1:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Outputs still show their value from before this edge
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic settle();
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic setc(input logic [15:0] v);
		@(posedge clk);
		set_en <= 1'b1;
		set_val <= v;
		@(posedge clk);
		set_en <= 1'b0;
		settle();
	endtask

	task automatic coil_to(input logic [15:0] v);
		@(posedge clk);
		coil <= v;
		settle();
	endtask

	// ********************************************************
	// Tests
	// ********************************************************
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		coil = '0;
		set_en = 1'b0;
		set_idx = '0;
		set_val = '0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, 12'h0C0, 32'h0);
		chk("ctrl3", 32'h31, r);
		chk("vis", 32'h0000FFFF, {16'h0, vis});
		apb(1'b0, 12'h408, 32'h0);
		chk("irq_en", 32'h0, r);
		apb(1'b0, 12'h01C, 32'h0);
		chk("slverr", 32'h1, {31'h0, e});
		chk("slv_data", 32'h0, r);
		for (i = 0; i < 4; i++) begin
			apb(1'b1, 12'h004 + 12'(4 * i),
				{16'(16'h2012 + 2 * i), 16'(16'h2011 + 2 * i)});
		end
		apb(1'b1, 12'h040, 32'h01);
		apb(1'b1, 12'h050, 32'h2011_0000);
		apb(1'b1, 12'h408, 32'h1);
		coil_to(16'h0003);
		for (i = 0; i < 8; i++) begin
			setc(16'(16'h2011 + i));
			chk("contacts", 32'(1 << i), {24'h0, ct[0]});
			chk("vector", 32'(1 << i), vec_out[0]);
			chk("status", 32'(16'h2011 + i), st_out[0]);
			chk("group", 32'h1, {31'h0, grp[0]});
			if (i == 0) begin
				chk("second", 32'h80, {24'h0, ct[1]});
				chk("irq_on", 32'h1, {31'h0, irq});
				apb(1'b0, 12'h400, 32'h0);
				chk("irq_st", 32'h3, r);
				apb(1'b1, 12'h404, 32'h3);
				settle();
				chk("irq_clr", 32'h0, {31'h0, irq});
			end
		end
		apb(1'b0, 12'h014, 32'h0);
		chk("status_reg", 32'h2018, r);
		apb(1'b0, 12'h018, 32'h0);
		chk("vector_reg", 32'h80, r);
		apb(1'b0, 12'h010, 32'h0);
		chk("sel67", 32'h2018_2017, r);
		apb(1'b1, 12'h014, 32'hFFFF_FFFF);
		chk("ro_err", 32'h0, {31'h0, e});
		apb(1'b0, 12'h404, 32'h0);
		chk("clr_read", 32'h0, r);
		apb(1'b1, 12'h000, 32'h05);
		settle();
		chk("byte", 32'h18, st_out[0]);
		apb(1'b1, 12'h000, 32'h02);
		settle();
		chk("word", 32'h2018, st_out[0]);
		chk("hidden", 32'h0, {31'h0, vis[0]});
		apb(1'b1, 12'h408, 32'h0);
		coil_to(16'h0000);
		chk("off_ct", 32'h0, {24'h0, ct[0]});
		chk("off_vec", 32'h0, vec_out[0]);
		chk("off_grp", 32'h0, {31'h0, grp[0]});
		chk("off_st", 32'h0, st_out[0]);
		coil_to(16'h0001);
		chk("masked", 32'h0, {31'h0, irq});
		apb(1'b0, 12'h400, 32'h0);
		chk("irq_st2", 32'h1, r & 32'h1);
		end_of_test();
	end
endmodule
